//--- verilog/rcd_decoder.sv
// Purpose: Command decoder and control register of a digital rheostat
// Assumes: Link pins come from another clock domain
// Notes:   Frames are framed by link_frame_n, bits sampled on sclk rise
//
// How it works
// - Wiper and fuse writes locked after power-up
// - Unlock bit resets 0, locks wiper
// - Reset reloads wiper even when locked
// - Fuse store needs program-enable bit set
// - Opcode 0 does nothing, shifts response
// - Opcode 1 loads wiper when unlocked
// - Opcode 2 returns wiper next frame
// - Opcode 3 stores wiper to next location
// - Opcode 4 reloads last stored wiper
// - Opcode 5 reads location D5..D0 next frame
// - Locations 0x01 to 0x32, zero reserved
// - Opcode 6 returns last programmed index
// - Opcode 7 writes three control bits
// - Opcode 8 returns control register
// - Opcode 9 D0 sets or clears shutdown
// - Control register four bits, upper zero
// - Calibration-disable defaults 0, 1 disables
// - Success bit set only on finished store
// - Locked wiper changes only on reload, to stored value or midscale
// - Each frame shifts previous frame's response
// - Frame: 16 bits MSB first, opcode, data
// - Stores begin at 0x01 and advance
// - Input shift register locked during store
// - Reset with empty store loads midscale
`timescale 1ns/100ps
`include "rcd_cfg.svh"
module rcd_decoder
    import rcd_pkg::*;
#(
    parameter int LOW_RES      = 0,
    parameter int STORE_CYCLES = `RCD_STORE_CYCLES
)
(
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       resetn,
    // Serial link pins
    input  wire logic                       link_sclk,
    input  wire logic                       link_sdi,
    input  wire logic                       link_frame_n,
    output logic                            serial_response_bit,
    // Hardware reset pin
    input  wire logic                       reset_pin_n,
    // Analog side controls
    output logic [`RCD_WIPER_BITS-1:0]      wiper_setting_register,
    output logic                            shutdown,
    output logic                            tolerance_cal_disable,
    output logic                            store_busy
);
    localparam int CNT_W = $clog2(STORE_CYCLES + 1);
    localparam logic [CNT_W-1:0] STORE_LAST = CNT_W'(STORE_CYCLES - 1);

    // Synchroniser stages
    logic [1:0] sclk_sync_q;
    logic [1:0] sdi_sync_q;
    logic [1:0] frame_sync_q;
    logic [1:0] rstpin_sync_q;
    logic       sclk_prev_q;
    logic       frame_prev_q;

    // Link shift state
    logic [`RCD_FRAME_BITS-1:0] shift_in_q;
    logic [4:0]                 bit_cnt_q;
    logic [`RCD_FRAME_BITS-1:0] shift_out_q;
    logic [`RCD_FRAME_BITS-1:0] serial_response_word_q;
    logic                       sdo_q;

    // Device state
    rcd_state_t                 state_q;
    logic [CNT_W-1:0]           store_cnt_q;
    logic [`RCD_IDX_BITS-1:0]   last_idx_q;
    logic [`RCD_IDX_BITS-1:0]   peek_idx_q;
    logic [`RCD_WIPER_BITS-1:0] wiper_q;
    logic                       shutdown_q;
    logic                       fuse_program_enable_q;
    logic                       wiper_write_unlock_q;
    logic                       tolerance_cal_disable_q;
    logic                       fuse_program_success_q;

    // Decoded events
    logic                       sclk_rise;
    logic                       sclk_fall;
    logic                       frame_start;
    logic                       frame_end;
    logic                       cmd_go;
    logic [3:0]                 op;
    logic [`RCD_WIPER_BITS-1:0] data;
    logic                       store_full;
    logic                       store_ok;
    logic                       hw_reset;
    logic [3:0]                 ctrl_bits;

    rcd_mem_if mem_bus ();

    // Zero-extends a field into a response word
    function automatic logic [`RCD_FRAME_BITS-1:0] rcd_pad
        (input logic [`RCD_WIPER_BITS-1:0] v);
        rcd_pad = {6'h00, v};
    endfunction

    // Masks the low bits the 256-step variant cannot hold
    function automatic logic [`RCD_WIPER_BITS-1:0] rcd_res
        (input logic [`RCD_WIPER_BITS-1:0] v);
        rcd_res = (LOW_RES != 0) ? {v[9:2], 2'b00} : v;
    endfunction

    // Two flops per pin; only stage 1 is read by logic
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_sync_q   <= 2'b00;
            sdi_sync_q    <= 2'b00;
            frame_sync_q  <= 2'b11;
            rstpin_sync_q <= 2'b11;
            sclk_prev_q   <= 1'b0;
            frame_prev_q  <= 1'b1;
        end
        else
        begin
            sclk_sync_q   <= {sclk_sync_q[0], link_sclk};
            sdi_sync_q    <= {sdi_sync_q[0], link_sdi};
            frame_sync_q  <= {frame_sync_q[0], link_frame_n};
            rstpin_sync_q <= {rstpin_sync_q[0], reset_pin_n};
            sclk_prev_q   <= sclk_sync_q[1];
            frame_prev_q  <= frame_sync_q[1];
        end
    end

    // Edge events on the synchronised link
    assign sclk_rise   = sclk_sync_q[1] & ~sclk_prev_q & ~frame_sync_q[1];
    assign sclk_fall   = ~sclk_sync_q[1] & sclk_prev_q & ~frame_sync_q[1];
    assign frame_start = ~frame_sync_q[1] & frame_prev_q;
    assign frame_end   = frame_sync_q[1] & ~frame_prev_q;
    assign hw_reset    = ~rstpin_sync_q[1];

    assign cmd_go = frame_end && (bit_cnt_q == 5'd16)
                    && (state_q == RCD_ST_IDLE);
    assign op   = shift_in_q[`RCD_OP_MSB:`RCD_OP_LSB];
    assign data = shift_in_q[`RCD_DATA_MSB:0];

    assign ctrl_bits = {fuse_program_success_q, tolerance_cal_disable_q,
                        wiper_write_unlock_q, fuse_program_enable_q};

    assign store_full = (last_idx_q == `RCD_IDX_BITS'(`RCD_STORE_DEPTH));
    assign store_ok = cmd_go && (op == RCD_OP_STORE)
                      && fuse_program_enable_q && !store_full && !hw_reset;

    // MSB-first input shift, locked when busy
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_in_q <= 16'h0000;
            bit_cnt_q  <= 5'h00;
        end
        else if (state_q == RCD_ST_IDLE)
        begin
            if (frame_start)
                bit_cnt_q <= 5'h00;
            else if (sclk_rise)
            begin
                shift_in_q <= {shift_in_q[14:0], sdi_sync_q[1]};
                // Saturate so long frames are rejected
                if (bit_cnt_q != 5'h1F)
                    bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    // previous response shifted out, MSB first
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_out_q <= 16'h0000;
            sdo_q       <= 1'b0;
        end
        else if (frame_start)
        begin
            shift_out_q <= {serial_response_word_q[14:0], 1'b0};
            sdo_q       <= serial_response_word_q[15];
        end
        else if (sclk_fall)
        begin
            shift_out_q <= {shift_out_q[14:0], 1'b0};
            sdo_q       <= shift_out_q[15];
        end
    end

    // Response prepared for the next frame
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            serial_response_word_q <= 16'h0000;
        else if (state_q == RCD_ST_PEEK_USE)
        begin
            // reserved or out-of-range index reads zero
            if (peek_idx_q == 6'h00 ||
                peek_idx_q > `RCD_IDX_BITS'(`RCD_STORE_DEPTH))
                serial_response_word_q <= 16'h0000;
            else
                serial_response_word_q <= rcd_pad(mem_bus.rd_data);
        end
        else if (cmd_go)
        begin
            case (op)
                RCD_OP_RD_WIPER:
                    serial_response_word_q <= rcd_pad(rcd_res(wiper_q));
                // last index in low six bits
                RCD_OP_RD_LAST:
                    serial_response_word_q <= {10'h000, last_idx_q};
                RCD_OP_RD_CTRL:
                    serial_response_word_q <= {12'h000, ctrl_bits};
                default:
                    serial_response_word_q <= shift_in_q;
            endcase
        end
    end

    // Sequencer: reloads, fuse peeks and the store wait
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q     <= RCD_ST_BOOT;
            store_cnt_q <= '0;
            peek_idx_q  <= 6'h00;
        end
        else
        begin
            case (state_q)
                RCD_ST_BOOT:
                    state_q <= RCD_ST_LOAD_USE;
                RCD_ST_IDLE:
                begin
                    if (hw_reset ||
                        (cmd_go && op == RCD_OP_SW_RESET))
                        state_q <= RCD_ST_LOAD_USE;
                    else if (cmd_go && op == RCD_OP_RD_FUSE)
                    begin
                        peek_idx_q <= data[`RCD_IDX_MSB:0];
                        state_q    <= RCD_ST_PEEK_USE;
                    end
                    else if (store_ok)
                    begin
                        store_cnt_q <= '0;
                        state_q     <= RCD_ST_STORE;
                    end
                end
                RCD_ST_LOAD_USE:
                    state_q <= RCD_ST_IDLE;
                RCD_ST_PEEK_USE:
                    state_q <= RCD_ST_IDLE;
                RCD_ST_STORE:
                begin
                    // link locked for the store time
                    if (store_cnt_q == STORE_LAST)
                        state_q <= RCD_ST_IDLE;
                    else
                        store_cnt_q <= store_cnt_q + CNT_W'(1);
                end
                default:
                    state_q <= RCD_ST_IDLE;
            endcase
        end
    end

    // Store port: read is requested the cycle before use
    assign mem_bus.rd_en   = (state_q == RCD_ST_BOOT)
                             || (state_q == RCD_ST_IDLE);
    assign mem_bus.rd_addr = (cmd_go && op == RCD_OP_RD_FUSE)
                             ? data[`RCD_IDX_MSB:0] : last_idx_q;
    // present wiper into next free location
    assign mem_bus.wr_en   = store_ok;
    assign mem_bus.wr_addr = last_idx_q + 6'h01;
    assign mem_bus.wr_data = rcd_res(wiper_q);

    rcd_fuse_store u_store
    (
        .core_clk (core_clk),
        .port     (mem_bus)
    );

    // index advances when a store completes
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            last_idx_q <= 6'h00;
        else if (state_q == RCD_ST_STORE && store_cnt_q == STORE_LAST)
            last_idx_q <= last_idx_q + 6'h01;
    end

    // Wiper register
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            wiper_q <= `RCD_WIPER_MIDSCALE;
        else if (state_q == RCD_ST_LOAD_USE)
        begin
            if (last_idx_q == 6'h00)
                wiper_q <= `RCD_WIPER_MIDSCALE;
            else
                wiper_q <= mem_bus.rd_data;
        end
        else if (cmd_go && op == RCD_OP_WR_WIPER && wiper_write_unlock_q)
            wiper_q <= rcd_res(data);
    end

    // Control register; undefined opcodes fall through untouched
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            // both write paths locked at power-up
            {fuse_program_success_q, tolerance_cal_disable_q,
             wiper_write_unlock_q, fuse_program_enable_q}
                <= `RCD_CTRL_RESET;
        end
        else
        begin
            // unlock comes only from this write
            if (cmd_go && op == RCD_OP_WR_CTRL)
            begin
                fuse_program_enable_q   <= data[`RCD_CTRL_PGM_EN];
                wiper_write_unlock_q    <= data[`RCD_CTRL_UNLOCK];
                tolerance_cal_disable_q <= data[`RCD_CTRL_CAL_DIS];
            end
            // success only after the store time
            if (state_q == RCD_ST_STORE && store_cnt_q == STORE_LAST)
                fuse_program_success_q <= 1'b1;
        end
    end

    // Shutdown; any reset also brings the part back up
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            shutdown_q <= 1'b0;
        else if (state_q == RCD_ST_LOAD_USE)
            shutdown_q <= 1'b0;
        else if (cmd_go && op == RCD_OP_SHUTDOWN)
            shutdown_q <= data[0];
    end

    // Outputs, each a flip-flop
    assign serial_response_bit    = sdo_q;
    assign wiper_setting_register = wiper_q;
    assign shutdown               = shutdown_q;
    assign tolerance_cal_disable  = tolerance_cal_disable_q;

    // Busy flag registered so the output comes from a flop
    logic store_busy_q;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            store_busy_q <= 1'b0;
        else
            store_busy_q <= store_ok ||
                (state_q == RCD_ST_STORE && store_cnt_q != STORE_LAST);
    end
    assign store_busy = store_busy_q;
endmodule // rcd_decoder

//--- verilog/rcd_cfg.svh
// Purpose: Constants for the rheostat command decoder
// Assumes: 10 MHz core clock
// Notes:   Field positions refer to the 16-bit command frame
`ifndef RCD_CFG_SVH
`define RCD_CFG_SVH

// Frame layout
`define RCD_FRAME_BITS      16
`define RCD_OP_MSB          13
`define RCD_OP_LSB          10
`define RCD_DATA_MSB        9
`define RCD_IDX_MSB         5

// Wiper and store geometry
`define RCD_WIPER_BITS      10
`define RCD_IDX_BITS        6
`define RCD_STORE_DEPTH     50
`define RCD_WIPER_MIDSCALE  10'h200

// Control register fields
`define RCD_CTRL_PGM_EN     0
`define RCD_CTRL_UNLOCK     1
`define RCD_CTRL_CAL_DIS    2
`define RCD_CTRL_SUCCESS    3
`define RCD_CTRL_RESET      4'h0

// Timing
`define RCD_CLK_HZ          10000000
`define RCD_STORE_TIME_MS   350
`define RCD_STORE_CYCLES    (`RCD_STORE_TIME_MS * (`RCD_CLK_HZ / 1000))

`endif

//--- verilog/rcd_pkg.sv
// Purpose: Types for the rheostat command decoder
// Assumes: Nothing beyond the cfg header
// Notes:   Opcode values are the frame encodings
package rcd_pkg;

    typedef enum logic [3:0] {
        RCD_OP_NOP      = 4'h0,
        RCD_OP_WR_WIPER = 4'h1,
        RCD_OP_RD_WIPER = 4'h2,
        RCD_OP_STORE    = 4'h3,
        RCD_OP_SW_RESET = 4'h4,
        RCD_OP_RD_FUSE  = 4'h5,
        RCD_OP_RD_LAST  = 4'h6,
        RCD_OP_WR_CTRL  = 4'h7,
        RCD_OP_RD_CTRL  = 4'h8,
        RCD_OP_SHUTDOWN = 4'h9
    } rcd_op_t;

    typedef enum {
        RCD_ST_BOOT,
        RCD_ST_IDLE,
        RCD_ST_LOAD_USE,
        RCD_ST_PEEK_USE,
        RCD_ST_STORE
    } rcd_state_t;

endpackage

//--- verilog/rcd_mem_if.sv
// Purpose: Port bundle between decoder and fuse wiper store
// Assumes: Single clock, read data one cycle after rd_en
// Notes:   None
`timescale 1ns/100ps
`include "rcd_cfg.svh"
interface rcd_mem_if;
    logic                         wr_en;
    logic [`RCD_IDX_BITS-1:0]     wr_addr;
    logic [`RCD_WIPER_BITS-1:0]   wr_data;
    logic                         rd_en;
    logic [`RCD_IDX_BITS-1:0]     rd_addr;
    logic [`RCD_WIPER_BITS-1:0]   rd_data;

    modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                  input  rd_data);
    modport mem  (input  wr_en, wr_addr, wr_data, rd_en, rd_addr,
                  output rd_data);
endinterface

//--- verilog/rcd_fuse_store.sv
// Purpose: Fuse wiper store, one word per location
// Assumes: Location 0 is never written
// Notes:   Read data registered, valid one cycle after rd_en
`timescale 1ns/100ps
`include "rcd_cfg.svh"
module rcd_fuse_store
(
    // Clock
    input wire logic core_clk,
    // Access port
    rcd_mem_if.mem   port
);
    localparam int DEPTH = 1 << `RCD_IDX_BITS;

    logic [`RCD_WIPER_BITS-1:0] cells [DEPTH];
    logic [`RCD_WIPER_BITS-1:0] rd_data_q;

    // Write; no reset, like real fuses
    always_ff @(posedge core_clk)
    begin
        if (port.wr_en)
            cells[port.wr_addr] <= port.wr_data;
    end

    // Registered read
    always_ff @(posedge core_clk)
    begin
        if (port.rd_en)
            rd_data_q <= cells[port.rd_addr];
    end

    assign port.rd_data = rd_data_q;
endmodule // rcd_fuse_store

//--- sim/rcd_decoder_asserts.sv
// Purpose: Port-level checks on the rheostat command decoder
// Assumes: Frames end with link_frame_n high before decode
// Notes:   Bound to every rcd_decoder instance
`timescale 1ns/100ps
`include "rcd_cfg.svh"
module rcd_decoder_chk
#(
    parameter int STORE_CYCLES = 20
)
(
    // Clock and reset
    input wire logic                       core_clk,
    input wire logic                       resetn,
    // Link and reset pins
    input wire logic                       link_sclk,
    input wire logic                       link_sdi,
    input wire logic                       link_frame_n,
    input wire logic                       serial_response_bit,
    input wire logic                       reset_pin_n,
    // Analog side
    input wire logic [`RCD_WIPER_BITS-1:0] wiper_setting_register,
    input wire logic                       shutdown,
    input wire logic                       tolerance_cal_disable,
    input wire logic                       store_busy
);
    // Slack over the store wait for the decode pipeline
    localparam int BUSY_MAX = STORE_CYCLES + 4;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // Outputs right after reset release
    property p_rst_mid;
        $rose(resetn) |-> wiper_setting_register == `RCD_WIPER_MIDSCALE
                          && !store_busy;
    endproperty
    a_rst_mid: assert property (p_rst_mid)
        else $error("wiper not midscale after reset");
    property p_rst_cal;
        $rose(resetn) |-> !tolerance_cal_disable && !shutdown;
    endproperty
    a_rst_cal: assert property (p_rst_cal)
        else $error("control outputs not cleared by reset");
    // Changes only once a frame has closed
    property p_wiper_quiet;
        $changed(wiper_setting_register) |->
            $past(link_frame_n) && $past(link_frame_n, 2);
    endproperty
    a_wiper_quiet: assert property (p_wiper_quiet)
        else $error("wiper moved inside a frame");
    property p_cal_quiet;
        $changed(tolerance_cal_disable) |-> $past(link_frame_n, 2);
    endproperty
    a_cal_quiet: assert property (p_cal_quiet)
        else $error("calibration bit moved inside a frame");
    property p_shut_quiet;
        $rose(shutdown) |-> $past(link_frame_n, 2);
    endproperty
    a_shut_quiet: assert property (p_shut_quiet)
        else $error("shutdown entered inside a frame");
    // Store wait: starts after a frame, lasts, then ends
    property p_busy_start;
        $rose(store_busy) |-> $past(link_frame_n, 2);
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("store began inside a frame");
    property p_busy_min;
        $rose(store_busy) |-> store_busy [*8];
    endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("store wait too short");
    // Busy run length; full store time is too long for a delay range
    logic [31:0] busy_run_q;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            busy_run_q <= 32'h0000_0000;
        else if (store_busy)
            busy_run_q <= busy_run_q + 32'h0000_0001;
        else
            busy_run_q <= 32'h0000_0000;
    end
    property p_busy_max;
        store_busy |-> busy_run_q < 32'(BUSY_MAX);
    endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("store wait too long");
    property p_busy_hold;
        store_busy && $past(store_busy) |->
            $stable(wiper_setting_register) && $stable(shutdown);
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("state changed during store");

    // Main scenarios reached
    c_store: cover property ($rose(store_busy));
    c_wiper: cover property ($changed(wiper_setting_register));
    c_shut: cover property ($rose(shutdown));
endmodule // rcd_decoder_chk

bind rcd_decoder rcd_decoder_chk #(.STORE_CYCLES(STORE_CYCLES)) u_chk
(
    .core_clk              (core_clk),
    .resetn                (resetn),
    .link_sclk             (link_sclk),
    .link_sdi              (link_sdi),
    .link_frame_n          (link_frame_n),
    .serial_response_bit   (serial_response_bit),
    .reset_pin_n           (reset_pin_n),
    .wiper_setting_register(wiper_setting_register),
    .shutdown              (shutdown),
    .tolerance_cal_disable (tolerance_cal_disable),
    .store_busy            (store_busy)
);

//--- sim/rcd_link_host.sv
// Purpose: Host side of the framed serial link
// Assumes: Link clock period 800 ns, made from core_clk edges
// Notes:   Link clock stands low between frames
`timescale 1ns/100ps
module rcd_link_host
(
    // Clock
    input wire logic core_clk,
    // Link pins
    output logic     sclk,
    output logic     sdi,
    output logic     frame_n,
    input wire logic serial_response_word
);
    // Idle levels at time zero
    initial
    begin
        sclk = 1'b0;
        sdi = 1'b0;
        frame_n = 1'b1;
    end

    // One frame of n bits; response captured before each rise
    task automatic xfer(input logic [15:0] w, input int n,
                        output logic [15:0] r);
        r = 16'h0000;
        @(posedge core_clk) frame_n <= 1'b0;
        for (int i = 15; i > 15 - n; i--)
        begin
            @(posedge core_clk) sdi <= w[i];
            repeat (3) @(posedge core_clk);
            r = {r[14:0], serial_response_word};
            sclk <= 1'b1;
            repeat (4) @(posedge core_clk);
            sclk <= 1'b0;
        end
        // Released data line flips so no stale bit is seen
        @(posedge core_clk) frame_n <= 1'b1;
        sdi <= ~sdi;
        repeat (8) @(posedge core_clk);
    endtask
endmodule // rcd_link_host

//--- sim/tb.sv
// Purpose: Self-checking bench for the rheostat command decoder
// Assumes: Short store wait of 200 cycles
// Notes:   Each frame's response is judged in the next frame
`timescale 1ns/100ps
`include "rcd_cfg.svh"
`define RCD_CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("[ERR] %0t got %h exp %h", $time, got, exp); \
        end \
    end
module tb;
    import rcd_pkg::*;
    logic                       core_clk;
    logic                       resetn;
    logic                       reset_pin_n;
    logic                       sclk;
    logic                       sdi;
    logic                       frame_n;
    logic                       serial_response_word;
    logic [`RCD_WIPER_BITS-1:0] wiper;
    logic                       shut;
    logic                       cal;
    logic                       busy;
    logic [15:0]                rsp;
    int                         bad_count;
    int                         comparisons;

    rcd_decoder #(.LOW_RES(0), .STORE_CYCLES(200)) DUT
    (
        .core_clk              (core_clk),
        .resetn                (resetn),
        .link_sclk             (sclk),
        .link_sdi              (sdi),
        .link_frame_n          (frame_n),
        .serial_response_bit   (serial_response_word),
        .reset_pin_n           (reset_pin_n),
        .wiper_setting_register(wiper),
        .shutdown              (shut),
        .tolerance_cal_disable (cal),
        .store_busy            (busy)
    );
    rcd_link_host hm
    (
        .core_clk(core_clk),
        .sclk    (sclk),
        .sdi     (sdi),
        .frame_n (frame_n),
        .serial_response_word     (serial_response_word)
    );

    // Link helpers
    task snd(input logic [3:0] op, input logic [9:0] d);
        hm.xfer({2'b00, op, d}, 16, rsp);
    endtask
    task rd(input logic [3:0] op, input logic [9:0] d,
            input logic [15:0] exp);
        snd(op, d);
        snd(RCD_OP_NOP, 10'h000);
        `RCD_CHK(rsp, exp)
    endtask
    // Bounded wait for the store to finish
    task wait_idle();
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            @(posedge core_clk);
        `RCD_CHK(busy, 1'b0)
        repeat (4) @(posedge core_clk);
    endtask

    task t_power();
        `RCD_CHK(wiper, `RCD_WIPER_MIDSCALE)
        `RCD_CHK({shut, cal, busy}, 3'b000)
        rd(RCD_OP_RD_CTRL, 10'h000, 16'h0000);
        snd(RCD_OP_WR_WIPER, 10'h155);
        `RCD_CHK(wiper, `RCD_WIPER_MIDSCALE)
        snd(RCD_OP_STORE, 10'h000);
        `RCD_CHK(busy, 1'b0)
        rd(RCD_OP_RD_LAST, 10'h000, 16'h0000);
        $display("t_power done");
    endtask

    task t_write();
        // Host unlocks before moving the wiper
        snd(RCD_OP_WR_CTRL, 10'h003);
        snd(RCD_OP_WR_WIPER, 10'h100);
        `RCD_CHK(rsp, 16'h1C03)
        `RCD_CHK(wiper, 10'h100)
        rd(RCD_OP_RD_WIPER, 10'h000, 16'h0100);
        `RCD_CHK(wiper, 10'h100)
        $display("t_write done");
    endtask

    task t_store();
        snd(RCD_OP_STORE, 10'h000);
        `RCD_CHK(busy, 1'b1)
        snd(RCD_OP_WR_WIPER, 10'h3FF);
        `RCD_CHK(wiper, 10'h100)
        wait_idle();
        rd(RCD_OP_RD_CTRL, 10'h000, 16'h000B);
        rd(RCD_OP_RD_LAST, 10'h000, 16'h0001);
        rd(RCD_OP_RD_FUSE, 10'h001, 16'h0100);
        rd(RCD_OP_RD_FUSE, 10'h000, 16'h0000);
        rd(RCD_OP_RD_FUSE, 10'h033, 16'h0000);
        snd(RCD_OP_WR_WIPER, 10'h2A5);
        snd(RCD_OP_STORE, 10'h000);
        wait_idle();
        rd(RCD_OP_RD_LAST, 10'h000, 16'h0002);
        rd(RCD_OP_RD_FUSE, 10'h002, 16'h02A5);
        $display("t_store done");
    endtask

    task t_ctrl();
        snd(RCD_OP_WR_CTRL, 10'h006);
        `RCD_CHK(cal, 1'b1)
        rd(RCD_OP_RD_CTRL, 10'h000, 16'h000E);
        snd(RCD_OP_SHUTDOWN, 10'h001);
        `RCD_CHK(shut, 1'b1)
        snd(RCD_OP_SHUTDOWN, 10'h000);
        `RCD_CHK(shut, 1'b0)
        snd(RCD_OP_WR_WIPER, 10'h011);
        snd(RCD_OP_SHUTDOWN, 10'h001);
        // Hardware reset pin pulse while idle
        @(posedge core_clk) reset_pin_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        reset_pin_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        `RCD_CHK(wiper, 10'h2A5)
        `RCD_CHK(shut, 1'b0)
        snd(RCD_OP_WR_WIPER, 10'h011);
        snd(RCD_OP_WR_CTRL, 10'h000);
        snd(RCD_OP_WR_WIPER, 10'h0F0);
        `RCD_CHK(wiper, 10'h011)
        snd(RCD_OP_SW_RESET, 10'h000);
        `RCD_CHK(wiper, 10'h2A5)
        $display("t_ctrl done");
    endtask

    task t_misc();
        snd(RCD_OP_WR_CTRL, 10'h002);
        for (logic [4:0] o = 5'd10; o < 5'd16; o++)
        begin
            snd(o[3:0], 10'h3FF);
            `RCD_CHK(wiper, 10'h2A5)
        end
        snd(RCD_OP_NOP, 10'h000);
        `RCD_CHK(rsp, 16'h3FFF)
        // Frame one bit short is dropped
        hm.xfer({2'b00, 4'h1, 10'h055}, 15, rsp);
        `RCD_CHK(wiper, 10'h2A5)
        $display("t_misc done");
    endtask

    // Verdict and end of run
    task print_verdict();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Core clock, 100 ns
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Watchdog well beyond the expected 7k cycles
    initial
    begin
        repeat (40000) @(posedge core_clk);
        bad_count++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        bad_count = 0;
        comparisons = 0;
        resetn = 1'b0;
        reset_pin_n = 1'b1;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_power();
        t_write();
        t_store();
        t_ctrl();
        t_misc();
        print_verdict();
    end
endmodule // tb
